// ---- dv/limux_term_model.sv ----
// Terminal-side model that issues management commands one at a time
`timescale 1ns/100ps
`default_nettype none
module limux_term_model
(
  input  wire logic                  core_clk_i,
  input  wire logic                  cmd_ready_i,
  input  wire logic                  rsp_last_i,
  output var  logic                  cmd_valid_o,
  output var  limux_pkg::limux_cmd_t cmd_o
);
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_o       = '0;
  end

  // ==========================================================================
  // Command issue
  // Holds the command until the accepting edge, then scrambles the released bus
  task automatic send(input limux_pkg::limux_cmd_t c, input int gap);
    int n;
    n = 0;
    repeat (gap) @(posedge core_clk_i);
    do @(posedge core_clk_i); while (cmd_ready_i !== 1'b1 && ++n < 200);
    cmd_valid_o <= 1'b1;
    cmd_o       <= c;
    @(posedge core_clk_i);
    cmd_valid_o <= 1'b0;
    cmd_o       <= ~c;
    // Next command only after the closing status byte
    do @(posedge core_clk_i); while (rsp_last_i !== 1'b1 && ++n < 200);
  endtask : send
endmodule : limux_term_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the management command interpreter
`timescale 1ns/100ps
`default_nettype none
`include "limux_regs.svh"
module tb_top;
  logic                  core_clk_i, rst_i, session_start_i, card_opt_nad_i;
  logic                  nad_sel_valid_i, cmd_valid_i, atr_we_i;
  logic [4:0]            nad_sel_idx_i, atr_waddr_i, active_idx_o, max_idx_o;
  logic [7:0]            atr_wdata_i, atr_len_i, rsp_data_o, clf_idx_o;
  logic                  cmd_ready_o, rsp_valid_o, rsp_last_o, elem_rst_o, nad_mode_o;
  limux_pkg::limux_cmd_t cmd_i;
  logic [8:0]            expq[$];
  logic [7:0]            atr[32];
  logic [31:0]           lfsr;
  int                    fails, cmp_count, cycles, rst_seen, atr_n, n;

  limux_cmd limux_cmd_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .session_start_i(session_start_i), .card_opt_nad_i(card_opt_nad_i),
    .nad_sel_valid_i(nad_sel_valid_i), .nad_sel_idx_i(nad_sel_idx_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .atr_we_i(atr_we_i),
    .atr_waddr_i(atr_waddr_i), .atr_wdata_i(atr_wdata_i), .atr_len_i(atr_len_i),
    .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .rsp_last_o(rsp_last_o), .active_idx_o(active_idx_o), .clf_idx_o(clf_idx_o),
    .elem_rst_o(elem_rst_o), .nad_mode_o(nad_mode_o), .max_idx_o(max_idx_o));

  limux_term_model limux_term_model_inst (.core_clk_i(core_clk_i),
    .cmd_ready_i(cmd_ready_o), .rsp_last_i(rsp_last_o),
    .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i));

  always #2.5 core_clk_i = ~core_clk_i;

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  // ==========================================================================
  // Compare and report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t state got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rsp(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t reply got %h exp %h", $time, got, exp);
    end
  endtask : chk_rsp

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // ==========================================================================
  // Reply watcher: an unexpected byte meets an unknown note and fails
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles > 6000)
    begin
      fails++;
      print_verdict();
    end
    if (elem_rst_o === 1'b1)
      rst_seen++;
    if (rsp_valid_o === 1'b1)
      chk_rsp({rsp_last_o, rsp_data_o}, expq.size() > 0 ? expq.pop_front() : 'x);
  end

  // ==========================================================================
  // Expectation and stimulus helpers
  task automatic push(input logic [7:0] b, input logic last);
    expq.push_back({last, b});
  endtask : push

  task automatic push_sw(input logic [15:0] sw);
    push(sw[15:8], 1'b0);
    push(sw[7:0], 1'b1);
  endtask : push_sw

  task automatic push_tlv(input logic [7:0] tag, input logic [7:0] v);
    push(tag, 1'b0);
    push(`LIMUX_LEN_ONE, 1'b0);
    push(v, 1'b0);
  endtask : push_tlv

  task automatic push_atr();
    push(`LIMUX_TAG_MAIN, 1'b0);
    push(8'(atr_n), 1'b0);
    for (int i = 0; i < atr_n; i++) push(atr[i], 1'b0);
    push_sw(`LIMUX_SW_OK);
  endtask : push_atr

  task automatic cmd(input logic [7:0] op, input logic [7:0] idx, input logic [7:0] prop,
                     input logic optp, input logic [7:0] opt);
    limux_pkg::limux_cmd_t c;
    c = '{op: op, idx: idx, prop_max: prop, opt_present: optp, opt: opt};
    lfsr = lfsr_next(lfsr);
    limux_term_model_inst.send(c, int'(lfsr[1:0]));
  endtask : cmd

  task automatic pulse_session();
    @(posedge core_clk_i);
    session_start_i <= 1'b1;
    @(posedge core_clk_i);
    session_start_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
  endtask : pulse_session

  // ==========================================================================
  // Main sequence
  initial
  begin
    {core_clk_i, session_start_i, card_opt_nad_i, nad_sel_valid_i, atr_we_i} = '0;
    {nad_sel_idx_i, atr_waddr_i, atr_wdata_i, atr_len_i} = '0;
    rst_i = 1'b1;
    lfsr  = 32'h8580512f;
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    chk({3'h0, active_idx_o}, `LIMUX_IDX_ZERO);
    chk(clf_idx_o, `LIMUX_NONE_ASSIGNED);
    // Random answer-to-reset, length 1 to 32
    atr_n = int'(lfsr[4:0]) + 1;
    for (int i = 0; i < atr_n; i++)
    begin
      lfsr = lfsr_next(lfsr);
      atr[i] = lfsr[7:0];
      @(posedge core_clk_i);
      atr_we_i    <= 1'b1;
      atr_waddr_i <= 5'(i);
      atr_wdata_i <= atr[i];
    end
    @(posedge core_clk_i);
    atr_we_i  <= 1'b0;
    atr_len_i <= 8'(atr_n);
    // Before configure only index zero is in range
    push_sw(`LIMUX_SW_BAD_P2);
    cmd(`LIMUX_OP_SELECT, 8'h03, 8'h00, 1'b0, 8'h00);
    chk({3'h0, active_idx_o}, `LIMUX_IDX_ZERO);
    // Card offers node selection, terminal sends no option TLV
    card_opt_nad_i <= 1'b1;
    push_tlv(`LIMUX_TAG_MAIN, 8'h05);
    push_tlv(`LIMUX_TAG_OPT, 8'h00);
    push_sw(`LIMUX_SW_OK);
    cmd(`LIMUX_OP_CONFIGURE, 8'h00, 8'h05, 1'b0, 8'hff);
    chk({3'h0, max_idx_o}, 8'h05);
    chk({7'h0, nad_mode_o}, 8'h00);
    push_sw(`LIMUX_SW_BAD_P1);
    cmd(`LIMUX_OP_CONFIGURE, 8'h00, 8'h1f, 1'b1, 8'h01);
    chk({3'h0, max_idx_o}, 8'h05);
    // Select up to one past the agreed maximum
    for (int i = 0; i < 7; i++)
    begin
      push_sw(i < 6 ? `LIMUX_SW_OK : `LIMUX_SW_BAD_P2);
      cmd(`LIMUX_OP_SELECT, 8'(i), 8'h00, 1'b0, 8'h00);
      chk({3'h0, active_idx_o}, i < 6 ? 8'(i) : 8'h05);
    end
    // Reserved operation codes and an index beyond the field range
    for (int k = 5; k < 10; k++)
    begin
      push_sw(`LIMUX_SW_BAD_P1);
      cmd(k < 9 ? 8'(k) : `LIMUX_OP_SELECT, k < 9 ? 8'h00 : 8'h20, 8'h00, 1'b0, 8'h00);
      chk({3'h0, active_idx_o}, 8'h05);
    end
    push_sw(`LIMUX_SW_BAD_P2);
    cmd(`LIMUX_OP_RETRIEVE, 8'h01, 8'h00, 1'b0, 8'h00);
    push_tlv(`LIMUX_TAG_MAIN, `LIMUX_NONE_ASSIGNED);
    push_sw(`LIMUX_SW_OK);
    cmd(`LIMUX_OP_RETRIEVE, 8'h00, 8'h00, 1'b0, 8'h00);
    // Reset one element, then hand the link to another
    n = rst_seen;
    push_atr();
    cmd(`LIMUX_OP_RESET, 8'h02, 8'h00, 1'b0, 8'h00);
    chk({3'h0, active_idx_o}, 8'h02);
    chk(8'(rst_seen - n), 8'h01);
    push_atr();
    cmd(`LIMUX_OP_ASSIGN, 8'h04, 8'h00, 1'b0, 8'h00);
    chk({3'h0, active_idx_o}, 8'h04);
    chk(clf_idx_o, 8'h04);
    chk(8'(rst_seen - n), 8'h02);
    push_tlv(`LIMUX_TAG_MAIN, 8'h04);
    push_sw(`LIMUX_SW_OK);
    cmd(`LIMUX_OP_RETRIEVE, 8'h00, 8'h00, 1'b0, 8'h00);
    // New session: index zero again, link holder survives
    pulse_session();
    chk({3'h0, active_idx_o}, `LIMUX_IDX_ZERO);
    chk(clf_idx_o, 8'h04);
    // Over-range proposal with node selection on both sides
    push_tlv(`LIMUX_TAG_MAIN, `LIMUX_IDX_MAX);
    push_tlv(`LIMUX_TAG_OPT, `LIMUX_OPT_MASK);
    push_sw(`LIMUX_SW_OK);
    cmd(`LIMUX_OP_CONFIGURE, 8'h00, 8'h40, 1'b1, 8'h01);
    chk({3'h0, max_idx_o}, `LIMUX_IDX_MAX);
    chk({7'h0, nad_mode_o}, 8'h01);
    @(posedge core_clk_i);
    nad_sel_valid_i <= 1'b1;
    nad_sel_idx_i   <= 5'h07;
    @(posedge core_clk_i);
    nad_sel_valid_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    chk({3'h0, active_idx_o}, 8'h07);
    push_atr();
    cmd(`LIMUX_OP_ASSIGN, `LIMUX_IDX_MAX, 8'h00, 1'b0, 8'h00);
    chk(clf_idx_o, `LIMUX_IDX_MAX);
    repeat (4) @(posedge core_clk_i);
    chk(8'(expq.size()), 8'h00);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire

// ---- rtl/limux_atr_mem.sv ----
// Answer-to-reset byte store with registered read data
`timescale 1ns/100ps
`default_nettype none
`include "limux_regs.svh"
module limux_atr_mem
(
  input  wire logic                     core_clk_i,
  input  wire logic                     we_i,
  input  wire logic [`LIMUX_ATR_AW-1:0] waddr_i,
  input  wire logic [7:0]               wdata_i,
  input  wire logic [`LIMUX_ATR_AW-1:0] raddr_i,
  output var  logic [7:0]               rdata_o
);
  logic [7:0] mem [`LIMUX_ATR_DEPTH];

  always_ff @(posedge core_clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule : limux_atr_mem
`default_nettype wire

// ---- rtl/limux_cmd.sv ----
// Logical interface management command interpreter
`timescale 1ns/100ps
`default_nettype none
`include "limux_regs.svh"
module limux_cmd
(
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     session_start_i,
  input  wire logic                     card_opt_nad_i,
  input  wire logic                     nad_sel_valid_i,
  input  wire logic [4:0]               nad_sel_idx_i,
  input  wire logic                     cmd_valid_i,
  input  wire limux_pkg::limux_cmd_t    cmd_i,
  input  wire logic                     atr_we_i,
  input  wire logic [`LIMUX_ATR_AW-1:0] atr_waddr_i,
  input  wire logic [7:0]               atr_wdata_i,
  input  wire logic [7:0]               atr_len_i,
  output var  logic                     cmd_ready_o,
  output var  logic                     rsp_valid_o,
  output var  logic [7:0]               rsp_data_o,
  output var  logic                     rsp_last_o,
  output var  logic [4:0]               active_idx_o,
  output var  logic [7:0]               clf_idx_o,
  output var  logic                     elem_rst_o,
  output var  logic                     nad_mode_o,
  output var  logic [4:0]               max_idx_o
);
  limux_pkg::limux_st_t st;
  limux_pkg::limux_st_t next_st;
  logic [7:0]           atr_rdata;
  logic [4:0]           atr_raddr;

  // ===========================================================
  // ATR store
  assign atr_raddr = next_st.rsp_cnt[`LIMUX_ATR_AW-1:0];

  limux_atr_mem u_atr
  (
    .core_clk_i (core_clk_i),
    .we_i       (atr_we_i),
    .waddr_i    (atr_waddr_i),
    .wdata_i    (atr_wdata_i),
    .raddr_i    (atr_raddr),
    .rdata_o    (atr_rdata)
  );

  // Checks the index against the agreed range
  function automatic logic idx_ok(input logic [7:0] idx, input logic [4:0] mx);
    idx_ok = (idx <= `LIMUX_IDX_MAX) && (idx[4:0] <= mx);
  endfunction : idx_ok

  // ===========================================================
  // Next state
  always_comb
  begin
    logic [7:0] prop;
    logic       bad;
    prop = 8'h00;
    bad = 1'b0;
    next_st = st;
    next_st.elem_rst = 1'b0;
    next_st.rsp_valid = 1'b0;
    next_st.rsp_last = 1'b0;
    if (session_start_i)
    begin
      // Link holder survives session resets on purpose
      next_st.active_idx = 5'h00;
      next_st.configured = 1'b0;
      next_st.max_idx = 5'h00;
      next_st.nad_mode = 1'b0;
    end
    else if (nad_sel_valid_i && st.nad_mode && idx_ok({3'h0, nad_sel_idx_i}, st.max_idx))
    begin
      next_st.active_idx = nad_sel_idx_i;
    end
    case (st.state)
      limux_pkg::LIMUX_IDLE:
      begin
        next_st.cmd_ready = 1'b1;
        if (cmd_valid_i && !session_start_i)
        begin
          next_st.cmd_ready = 1'b0;
          next_st.sw = `LIMUX_SW_OK;
          next_st.rsp_len = 8'h00;
          next_st.rsp_cnt = 8'h00;
          if (cmd_i.op == `LIMUX_OP_CONFIGURE)
          begin
            bad = (cmd_i.idx != `LIMUX_IDX_ZERO) || st.configured;
          end
          else if (cmd_i.op == `LIMUX_OP_RETRIEVE)
          begin
            bad = cmd_i.idx != `LIMUX_IDX_ZERO;
          end
          else if (cmd_i.op <= `LIMUX_OP_ASSIGN)
          begin
            bad = !idx_ok(cmd_i.idx, st.max_idx);
          end
          else
          begin
            bad = 1'b1;
          end
          if (bad)
          begin
            next_st.sw = `LIMUX_SW_BAD_P2;
            next_st.state = limux_pkg::LIMUX_SW1;
          end
          else if (cmd_i.op == `LIMUX_OP_SELECT)
          begin
            next_st.active_idx = cmd_i.idx[4:0];
            next_st.state = limux_pkg::LIMUX_SW1;
          end
          else if (cmd_i.op == `LIMUX_OP_CONFIGURE)
          begin
            prop = (cmd_i.prop_max > `LIMUX_IDX_MAX) ? `LIMUX_IDX_MAX : cmd_i.prop_max;
            next_st.max_idx = prop[4:0];
            // Absent option TLV reads as all zero
            next_st.nad_mode = card_opt_nad_i && cmd_i.opt_present
              && cmd_i.opt[`LIMUX_OPT_NAD_BIT];
            next_st.configured = 1'b1;
            next_st.hdr0 = `LIMUX_TAG_MAIN;
            next_st.hdr1 = `LIMUX_LEN_ONE;
            next_st.hdr2 = {3'h0, prop[4:0]};
            next_st.rsp_len = `LIMUX_CFG_RSP_LEN;
            next_st.state = limux_pkg::LIMUX_HDR;
          end
          else if (cmd_i.op == `LIMUX_OP_RETRIEVE)
          begin
            next_st.hdr0 = `LIMUX_TAG_MAIN;
            next_st.hdr1 = `LIMUX_LEN_ONE;
            next_st.hdr2 = st.clf_idx;
            next_st.rsp_len = `LIMUX_RET_RSP_LEN;
            next_st.state = limux_pkg::LIMUX_HDR;
          end
          else
          begin
            next_st.active_idx = cmd_i.idx[4:0];
            next_st.elem_rst = 1'b1;
            if (cmd_i.op == `LIMUX_OP_ASSIGN)
            begin
              next_st.clf_idx = cmd_i.idx;
            end
            next_st.hdr0 = `LIMUX_TAG_MAIN;
            next_st.hdr1 = atr_len_i;
            next_st.rsp_len = atr_len_i + `LIMUX_HDR_LEN;
            next_st.state = limux_pkg::LIMUX_HDR;
          end
        end
      end
      limux_pkg::LIMUX_HDR:
      begin
        next_st.rsp_valid = 1'b1;
        next_st.rsp_data = (st.rsp_cnt == 8'h00) ? st.hdr0 : st.hdr1;
        next_st.rsp_cnt = st.rsp_cnt + 8'h01;
        if (st.rsp_cnt == 8'h01)
        begin
          next_st.rsp_cnt = 8'h00;
          next_st.state = limux_pkg::LIMUX_BODY;
        end
      end
      limux_pkg::LIMUX_BODY:
      begin
        if (st.rsp_cnt + `LIMUX_HDR_LEN >= st.rsp_len)
        begin
          next_st.state = limux_pkg::LIMUX_SW1;
        end
        else
        begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_cnt = st.rsp_cnt + 8'h01;
          if (st.rsp_len == `LIMUX_CFG_RSP_LEN)
          begin
            next_st.rsp_data = (st.rsp_cnt == 8'h00) ? st.hdr2
              : (st.rsp_cnt == 8'h01) ? `LIMUX_TAG_OPT
              : (st.rsp_cnt == 8'h02) ? `LIMUX_LEN_ONE
              : {7'h00, st.nad_mode};
          end
          else
          begin
            next_st.rsp_data = (st.rsp_len == `LIMUX_RET_RSP_LEN) ? st.hdr2 : atr_rdata;
          end
        end
      end
      limux_pkg::LIMUX_SW1:
      begin
        next_st.rsp_valid = 1'b1;
        next_st.rsp_data = st.sw[15:8];
        next_st.state = limux_pkg::LIMUX_SW2;
      end
      limux_pkg::LIMUX_SW2:
      begin
        next_st.rsp_valid = 1'b1;
        next_st.rsp_data = st.sw[7:0];
        next_st.rsp_last = 1'b1;
        next_st.cmd_ready = 1'b1;
        next_st.state = limux_pkg::LIMUX_IDLE;
      end
      default:
      begin
        next_st.state = limux_pkg::LIMUX_IDLE;
      end
    endcase
  end

  // ===========================================================
  // State register
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      st.state <= limux_pkg::LIMUX_IDLE;
      st.clf_idx <= `LIMUX_NONE_ASSIGNED;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign cmd_ready_o = st.cmd_ready;
  assign rsp_valid_o = st.rsp_valid;
  assign rsp_data_o = st.rsp_data;
  assign rsp_last_o = st.rsp_last;
  assign active_idx_o = st.active_idx;
  assign clf_idx_o = st.clf_idx;
  assign elem_rst_o = st.elem_rst;
  assign nad_mode_o = st.nad_mode;
  assign max_idx_o = st.max_idx;

  // ===========================================================
  // Assertions
  AST_SESSION_ZERO: assert property (@(posedge core_clk_i) disable iff (rst_i)
    session_start_i |=> active_idx_o == 5'h00)
    else $error("active index not zero after session start");
  AST_SELECT: assert property (@(posedge core_clk_i) disable iff (rst_i)
    st.state == limux_pkg::LIMUX_IDLE && cmd_valid_i && !session_start_i
    && cmd_i.op == `LIMUX_OP_SELECT && idx_ok(cmd_i.idx, st.max_idx)
    |=> active_idx_o == $past(cmd_i.idx[4:0]) ##1 rsp_valid_o ##1 rsp_last_o)
    else $error("select did not route");
  AST_RESET_ELEM: assert property (@(posedge core_clk_i) disable iff (rst_i)
    st.state == limux_pkg::LIMUX_IDLE && cmd_valid_i && !session_start_i
    && cmd_i.op == `LIMUX_OP_RESET && idx_ok(cmd_i.idx, st.max_idx)
    |=> elem_rst_o && active_idx_o == $past(cmd_i.idx[4:0]))
    else $error("reset element missing");
  AST_ASSIGN: assert property (@(posedge core_clk_i) disable iff (rst_i)
    st.state == limux_pkg::LIMUX_IDLE && cmd_valid_i && !session_start_i
    && cmd_i.op == `LIMUX_OP_ASSIGN && idx_ok(cmd_i.idx, st.max_idx)
    |=> elem_rst_o && clf_idx_o == $past(cmd_i.idx))
    else $error("assign did not record link");
  AST_LINK_KEPT: assert property (@(posedge core_clk_i) disable iff (rst_i)
    session_start_i |=> $stable(clf_idx_o))
    else $error("link holder lost on session reset");
  AST_CLAMP: assert property (@(posedge core_clk_i) disable iff (rst_i)
    st.state == limux_pkg::LIMUX_IDLE && cmd_valid_i && !session_start_i
    && cmd_i.op == `LIMUX_OP_CONFIGURE && cmd_i.idx == `LIMUX_IDX_ZERO && !st.configured
    |=> {3'h0, max_idx_o} == (($past(cmd_i.prop_max) > `LIMUX_IDX_MAX) ? `LIMUX_IDX_MAX
      : $past(cmd_i.prop_max)))
    else $error("proposed maximum not clamped");
  AST_NAD_AGREE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(nad_mode_o) |-> $past(card_opt_nad_i) && $past(cmd_i.opt_present)
    && $past(cmd_i.opt[`LIMUX_OPT_NAD_BIT]))
    else $error("node selection agreed without both sides");
  AST_REJECT: assert property (@(posedge core_clk_i) disable iff (rst_i)
    st.state == limux_pkg::LIMUX_IDLE && cmd_valid_i && !session_start_i
    && cmd_i.op > `LIMUX_OP_CONFIGURE
    |=> $stable(active_idx_o) && !elem_rst_o ##1 rsp_data_o == `LIMUX_SW_BAD_P1 >> 8)
    else $error("reserved op not rejected");
  AST_RSP_TAG: assert property (@(posedge core_clk_i) disable iff (rst_i)
    st.state == limux_pkg::LIMUX_HDR && st.rsp_cnt == 8'h00
    |=> rsp_valid_o && rsp_data_o == `LIMUX_TAG_MAIN)
    else $error("reply tag wrong");
  COV_SELECT: cover property (@(posedge core_clk_i) cmd_valid_i && cmd_i.op == `LIMUX_OP_SELECT);
  COV_CONFIG: cover property (@(posedge core_clk_i) st.configured && nad_mode_o);
  COV_ASSIGN: cover property (@(posedge core_clk_i) clf_idx_o != `LIMUX_NONE_ASSIGNED);
endmodule : limux_cmd
`default_nettype wire

// ---- rtl/limux_pkg.sv ----
// Types of the interface management command block
package limux_pkg;
  typedef struct packed {
    logic [7:0]  op;
    logic [7:0]  idx;
    logic [7:0]  prop_max;
    logic        opt_present;
    logic [7:0]  opt;
  } limux_cmd_t;

  typedef enum logic [4:0] {
    LIMUX_IDLE = 5'b00001,
    LIMUX_HDR  = 5'b00010,
    LIMUX_BODY = 5'b00100,
    LIMUX_SW1  = 5'b01000,
    LIMUX_SW2  = 5'b10000
  } limux_state_t;

  typedef struct packed {
    limux_state_t state;
    logic [4:0]   active_idx;
    logic [7:0]   clf_idx;
    logic         configured;
    logic [4:0]   max_idx;
    logic         nad_mode;
    logic [7:0]   rsp_len;
    logic [7:0]   rsp_cnt;
    logic [7:0]   hdr0;
    logic [7:0]   hdr1;
    logic [7:0]   hdr2;
    logic [15:0]  sw;
    logic         rsp_valid;
    logic [7:0]   rsp_data;
    logic         rsp_last;
    logic         cmd_ready;
    logic         elem_rst;
  } limux_st_t;
endpackage : limux_pkg

// ---- rtl/limux_regs.svh ----
// Constants of the interface management command block
`ifndef LIMUX_REGS_SVH
`define LIMUX_REGS_SVH
`define LIMUX_OP_SELECT     8'h00
`define LIMUX_OP_RESET      8'h01
`define LIMUX_OP_ASSIGN     8'h02
`define LIMUX_OP_RETRIEVE   8'h03
`define LIMUX_OP_CONFIGURE  8'h04
`define LIMUX_IDX_MAX       8'h1f
`define LIMUX_IDX_ZERO      8'h00
`define LIMUX_TAG_MAIN      8'h80
`define LIMUX_TAG_OPT       8'h81
`define LIMUX_LEN_ONE       8'h01
`define LIMUX_NONE_ASSIGNED 8'hff
`define LIMUX_OPT_NAD_BIT   0
`define LIMUX_OPT_MASK      8'h01
`define LIMUX_SW_OK         16'h9000
`define LIMUX_SW_BAD_P1     16'h6a86
`define LIMUX_SW_BAD_P2     16'h6a86
`define LIMUX_SW_ORDER      16'h6985
`define LIMUX_ATR_DEPTH     32
`define LIMUX_ATR_AW        5
`define LIMUX_ATR_LEN_RST   6'h00
`define LIMUX_HDR_LEN       8'h02
`define LIMUX_CFG_RSP_LEN   8'h06
`define LIMUX_RET_RSP_LEN   8'h03
`endif
